// ### rtl/adc_conversion_mode_sequencer.sv
// conversion mode sequencer: reference, timing, modes, power-down and resets
`timescale 1ns/100ps
`include "adc_seq_defs.svh"

module adc_conversion_mode_sequencer
	import adc_seq_pkg::*;
#(
	parameter int POR_CYCLES = `POR_CYC
) (
	input  wire logic        core_clk,          // 100 MHz system clock
	input  wire logic        rst_n,             // supply reset, synchronous, active low
	input  wire logic        reset_pin_n,       // external reset pin, asynchronous
	input  wire logic [7:0]  reg_addr,          // register byte address
	input  wire logic [31:0] reg_wdata,         // register write data
	input  wire logic        reg_wr,            // write strobe
	input  wire logic        reg_rd,            // read strobe
	output logic      [31:0] reg_rdata,         // read data, cycle after strobe
	input  wire logic [23:0] conv_data,         // filter output word
	input  wire logic        result_ready_n_i,  // ready pin level
	output logic             result_ready_n_o,  // ready pin drive value
	output logic             result_ready_n_oe, // ready pin pulled low
	output logic             ref_ext_sel,       // 1: ext_ref_positive/negative pair
	output logic             analog_on,         // oscillator and analog powered
	output logic             modulator_rate,    // modulator clock strobe
	output logic             conv_start,        // conversion begins, clears filter
	output logic             ref_settled        // internal reference settled
);

	// -------------------------------------------------------------------------
	// declarations
	// -------------------------------------------------------------------------
	seq_state_t  state_q;
	logic [16:0] timer_q;
	logic [3:0]  cfg_q;
	logic        mode_q;
	logic        pd_pend_q;
	logic        ready_n_q;
	logic [23:0] result_q;
	logic        pin_meta_q, pin_sync_q;
	logic        rdy_meta_q, rdy_sync_q;
	logic [31:0] por_cnt_q;
	logic        cmd_rst_q;
	logic        gc_ack_q;
	logic [11:0] ref_cnt_q;
	logic        ref_settled_q;
	logic        analog_on_q;
	logic        mod_rate_q;
	logic        conv_start_q;
	logic        ready_oe_q;
	logic [31:0] rdata_q;
	logic        soft_rst;
	logic        half_tick, mod_tick;
	logic        wr_cmd, wr_cfg, wr_gc;
	logic        start_cmd, pd_cmd, rst_cmd, rdcmd;
	logic        done;
	logic        read_result;
	logic        cfg_restart;
	logic        new_cm;

	// register hit decode, shared by strobes
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
		return addr == off;
	endfunction

	// conversion length in oscillator half periods for rate and mode
	function automatic logic [16:0] period_half(input logic [1:0] rate, input logic single);
		logic [16:0] osc;
		osc = `CONT_OSC_20;
		case (rate_sel_t'(rate))
			RATE_20:   osc = single ? `SINGLE_OSC_20   : `CONT_OSC_20;
			RATE_90:   osc = single ? `SINGLE_OSC_90   : `CONT_OSC_90;
			RATE_330:  osc = single ? `SINGLE_OSC_330  : `CONT_OSC_330;
			RATE_1000: osc = single ? `SINGLE_OSC_1000 : `CONT_OSC_1000;
			default:   osc = `CONT_OSC_20;
		endcase
		return 17'(osc << 1);
	endfunction

	// -------------------------------------------------------------------------
	// reset sources
	// -------------------------------------------------------------------------
	// reset pin and ready pin pass two flip-flops
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			pin_meta_q <= 1'b1;
			pin_sync_q <= 1'b1;
			rdy_meta_q <= 1'b1;
			rdy_sync_q <= 1'b1;
		end
		else
		begin
			pin_meta_q <= reset_pin_n;
			pin_sync_q <= pin_meta_q;
			rdy_meta_q <= result_ready_n_i;
			rdy_sync_q <= rdy_meta_q;
		end
	end

	// power-on hold after the supplies come up
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			por_cnt_q <= 32'(POR_CYCLES);
		else if (por_cnt_q != 32'h0000_0000)
			por_cnt_q <= por_cnt_q - 32'h0000_0001;
	end

	// reset command or general call byte 06h, acted on one cycle later
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			cmd_rst_q <= 1'b0;
		else
			cmd_rst_q <= rst_cmd || (wr_gc && reg_wdata[7:0] == `GCALL_RESET);
	end

	assign soft_rst = !rst_n || !pin_sync_q || (por_cnt_q != 32'h0000_0000) || cmd_rst_q;

	// -------------------------------------------------------------------------
	// command and register strobes, decoded combinationally from the bus, not registered
	// -------------------------------------------------------------------------
	assign wr_cmd      = reg_wr && hit(reg_addr, `REG_CMD);
	assign wr_cfg      = reg_wr && hit(reg_addr, `REG_CFG);
	assign wr_gc       = reg_wr && hit(reg_addr, `REG_GCALL);
	assign start_cmd   = wr_cmd && reg_wdata[7:0] == `CMD_START;
	assign pd_cmd      = wr_cmd && reg_wdata[7:0] == `CMD_SLEEP;
	assign rst_cmd     = wr_cmd && (reg_wdata[7:0] == `CMD_RESET_A ||
	                                reg_wdata[7:0] == `CMD_RESET_B);
	assign rdcmd       = wr_cmd && reg_wdata[7:0] == `CMD_READ_RESULT;
	assign read_result = rdcmd || (reg_rd && hit(reg_addr, `REG_RESULT));
	assign new_cm      = reg_wdata[`CFG_MODE_BIT];
	assign cfg_restart = wr_cfg && state_q == ST_CONV;
	assign done        = state_q == ST_CONV && half_tick && timer_q == 17'h0_0001;

	// -------------------------------------------------------------------------
	// configuration register
	// -------------------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (soft_rst)
			cfg_q <= `CFG_RESET;
		else if (wr_cfg)
			cfg_q <= reg_wdata[3:0];
	end

	// general call answered with write direction; flag kept until reset
	always_ff @(posedge core_clk)
	begin
		if (soft_rst)
			gc_ack_q <= 1'b0;
		else if (wr_gc)
			gc_ack_q <= 1'b1;
	end

	// -------------------------------------------------------------------------
	// sequencer: idle, lead-in delay, conversion
	// -------------------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (soft_rst)
		begin
			state_q <= ST_IDLE;
			timer_q <= 17'h0_0000;
			mode_q  <= 1'b0;
		end
		else if (start_cmd)
		begin
			mode_q <= cfg_q[`CFG_MODE_BIT];
			if (cfg_q[`CFG_MODE_BIT])
			begin
				state_q <= ST_LEAD;
				timer_q <= `LEAD_HALF_OSC;
			end
			else
			begin
				state_q <= ST_CONV;
				timer_q <= period_half(cfg_q[`CFG_RATE_MSB:`CFG_RATE_LSB], 1'b1);
			end
		end
		else if (cfg_restart && !mode_q)
		begin
			// behaves as a fresh start with the new settings
			mode_q <= new_cm;
			state_q <= new_cm ? ST_LEAD : ST_CONV;
			timer_q <= new_cm ? `LEAD_HALF_OSC
			                  : period_half(reg_wdata[`CFG_RATE_MSB:`CFG_RATE_LSB], 1'b1);
		end
		else if (cfg_restart)
			timer_q <= period_half(reg_wdata[`CFG_RATE_MSB:`CFG_RATE_LSB], 1'b0);
		else if (half_tick)
		begin
			case (state_q)
				ST_LEAD:
					if (timer_q == 17'h0_0001)
					begin
						state_q <= ST_CONV;
						timer_q <= period_half(cfg_q[`CFG_RATE_MSB:`CFG_RATE_LSB], 1'b0);
					end
					else
						timer_q <= timer_q - 17'h0_0001;
				ST_CONV:
					if (timer_q != 17'h0_0001)
						timer_q <= timer_q - 17'h0_0001;
					else if (mode_q && !(pd_pend_q || pd_cmd))
						timer_q <= period_half(cfg_q[`CFG_RATE_MSB:`CFG_RATE_LSB], 1'b0);
					else
					begin
						state_q <= ST_IDLE;
						timer_q <= 17'h0_0000;
					end
				default:
					timer_q <= 17'h0_0000;
			endcase
		end
	end

	// sleep request waits for the running conversion to end
	always_ff @(posedge core_clk)
	begin
		if (soft_rst || start_cmd || state_q == ST_IDLE)
			pd_pend_q <= 1'b0;
		else if (pd_cmd)
			pd_pend_q <= 1'b1;
	end

	// -------------------------------------------------------------------------
	// output buffer and ready flag
	// -------------------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (soft_rst)
			result_q <= 24'h00_0000;
		else if (done)
			result_q <= conv_data;
	end

	// completion pulls ready low and wins over a read in the same cycle
	always_ff @(posedge core_clk)
	begin
		if (soft_rst)
			ready_n_q <= 1'b1;
		else if (done)
			ready_n_q <= 1'b0;
		else if (read_result)
			ready_n_q <= 1'b1;
		else if (state_q == ST_CONV && mode_q && timer_q <= `READY_RELEASE_HALF)
			ready_n_q <= 1'b1;
	end

	// -------------------------------------------------------------------------
	// internal reference settling
	// -------------------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (soft_rst)
			ref_cnt_q <= 12'h000;
		else if ((start_cmd && state_q == ST_IDLE) ||
		         (wr_cfg && cfg_q[`CFG_REF_EXT_BIT] && !reg_wdata[`CFG_REF_EXT_BIT]))
			ref_cnt_q <= 12'(`REF_SETTLE_CYC);
		else if (ref_cnt_q != 12'h000)
			ref_cnt_q <= ref_cnt_q - 12'h001;
	end

	// -------------------------------------------------------------------------
	// oscillator, running only while not idle
	// -------------------------------------------------------------------------
	osc_tick_gen u_osc (
		.core_clk  (core_clk),
		.rst_n     (!soft_rst),
		.osc_en    (state_q != ST_IDLE),
		.half_tick (half_tick),
		.osc_tick  (),
		.mod_tick  (mod_tick)
	);

	// registered outputs
	always_ff @(posedge core_clk)
	begin
		if (soft_rst)
		begin
			analog_on_q   <= 1'b0;
			mod_rate_q    <= 1'b0;
			conv_start_q  <= 1'b0;
			ready_oe_q    <= 1'b0;
			ref_settled_q <= 1'b0;
		end
		else
		begin
			analog_on_q   <= state_q != ST_IDLE;
			mod_rate_q    <= mod_tick;
			conv_start_q  <= (start_cmd && !cfg_q[`CFG_MODE_BIT]) || cfg_restart ||
			                 (state_q == ST_LEAD && half_tick && timer_q == 17'h0_0001) ||
			                 (done && mode_q && !(pd_pend_q || pd_cmd));
			ready_oe_q    <= !ready_n_q;
			ref_settled_q <= ref_cnt_q == 12'h000;
		end
	end

	// -------------------------------------------------------------------------
	// register read port, data only in the cycle after the strobe
	// -------------------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (!rst_n || !reg_rd)
			rdata_q <= 32'h0000_0000;
		else if (hit(reg_addr, `REG_CFG))
			rdata_q <= {28'h000_0000, cfg_q};
		else if (hit(reg_addr, `REG_STATUS))
			rdata_q <= {24'h00_0000, rdy_sync_q, mode_q, gc_ack_q, pd_pend_q,
			            ref_settled_q, ready_n_q, state_q};
		else if (hit(reg_addr, `REG_RESULT))
			rdata_q <= {8'h00, result_q};
		else
			rdata_q <= 32'h0000_0000;
	end

	assign reg_rdata         = rdata_q;
	assign result_ready_n_o  = 1'b0;
	assign result_ready_n_oe = ready_oe_q;
	assign ref_ext_sel       = cfg_q[`CFG_REF_EXT_BIT];
	assign analog_on         = analog_on_q;
	assign modulator_rate    = mod_rate_q;
	assign conv_start        = conv_start_q;
	assign ref_settled       = ref_settled_q;

	// -------------------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	AST_REF_DEFAULT: assert property (soft_rst |=> !ref_ext_sel && cfg_q == 4'h0)
		else $error("reference not internal after reset");
	AST_SINGLE_LOAD: assert property (start_cmd && !soft_rst && !cfg_q[1] |=>
		state_q == ST_CONV && timer_q == period_half($past(cfg_q[3:2]), 1'b1))
		else $error("single-shot latency not loaded");
	AST_LEAD: assert property (start_cmd && !soft_rst && cfg_q[1] |=>
		state_q == ST_LEAD && timer_q == 17'h0_0039)
		else $error("continuous lead-in not 57 half periods");
	AST_CONT_NEXT: assert property (done && !soft_rst && mode_q && !pd_pend_q && !pd_cmd
		&& !start_cmd && !wr_cfg |=> state_q == ST_CONV && timer_q == period_half(cfg_q[3:2], 1'b0))
		else $error("continuous conversion not restarted");
	AST_SINGLE_END: assert property (done && !soft_rst && !mode_q && !start_cmd && !wr_cfg
		|=> state_q == ST_IDLE ##1 !analog_on)
		else $error("single-shot did not power off");
	AST_SLEEP: assert property (pd_pend_q && done && !soft_rst && !start_cmd && !wr_cfg
		|=> state_q == ST_IDLE && $stable(cfg_q))
		else $error("sleep did not follow completion");
	AST_CMD_RESET: assert property (rst_cmd |=> ##1 state_q == ST_IDLE && cfg_q == 4'h0)
		else $error("reset command ignored");
	AST_RESTART: assert property (cfg_restart && mode_q && !soft_rst && !start_cmd
		|=> timer_q == period_half($past(reg_wdata[3:2]), 1'b0))
		else $error("config write did not restart conversion");
	AST_READY_LOW: assert property (done && !soft_rst |=> !ready_n_q ##1 result_ready_n_oe)
		else $error("ready not asserted on completion");
	AST_READY_HIGH: assert property (read_result && !done && !soft_rst |=> ready_n_q)
		else $error("ready not released on read");
	AST_POR_HOLD: assert property (por_cnt_q != 32'h0000_0000 |=> state_q == ST_IDLE)
		else $error("activity during power-on hold");
	AST_MOD_RATE: assert property (disable iff (!rst_n || soft_rst)
		mod_tick && timer_q > 17'h0_0010 |-> ##[389:392] mod_tick)
		else $error("modulator strobe not every four oscillator periods");

endmodule // adc_conversion_mode_sequencer

// ### rtl/adc_seq_defs.svh
// constants for the conversion mode sequencer: offsets, fields, codes, timing
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

// -----------------------------------------------------------------------------
// register offsets (byte addresses)
// -----------------------------------------------------------------------------
`define REG_CMD            8'h00
`define REG_CFG            8'h04
`define REG_STATUS         8'h08
`define REG_RESULT         8'h0C
`define REG_GCALL          8'h10

// -----------------------------------------------------------------------------
// configuration fields and reset value
// -----------------------------------------------------------------------------
`define CFG_REF_EXT_BIT    0
`define CFG_MODE_BIT       1
`define CFG_RATE_LSB       2
`define CFG_RATE_MSB       3
`define CFG_RESET          4'h0

// -----------------------------------------------------------------------------
// command codes
// -----------------------------------------------------------------------------
`define CMD_RESET_A        8'h06
`define CMD_RESET_B        8'h07
`define CMD_START          8'h08
`define CMD_SLEEP          8'h02
`define CMD_READ_RESULT    8'h10
`define GCALL_RESET        8'h06

// -----------------------------------------------------------------------------
// timing: oscillator periods per conversion, clock rates, settle times
// -----------------------------------------------------------------------------
`define CONT_OSC_20        17'h0_C7F8
`define CONT_OSC_90        17'h0_2D0C
`define CONT_OSC_330       17'h0_0C2C
`define CONT_OSC_1000      17'h0_040C
`define SINGLE_OSC_20      17'h0_C80D
`define SINGLE_OSC_90      17'h0_2D25
`define SINGLE_OSC_330     17'h0_0C45
`define SINGLE_OSC_1000    17'h0_0425
`define LEAD_HALF_OSC      17'h0_0039
`define READY_RELEASE_HALF 17'h0_0004
`define HALF_OSC_KHZ       17'h0_0800
`define CORE_KHZ           17'h1_86A0
`define CLK_PERIOD_NS      10
`define REF_SETTLE_US      25
`define POR_TIME_US        500
`define REF_SETTLE_CYC     ((`REF_SETTLE_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POR_CYC            ((`POR_TIME_US * 1000) / `CLK_PERIOD_NS)

`endif

// ### rtl/adc_seq_pkg.sv
// types shared by the conversion mode sequencer
package adc_seq_pkg;

	// sequencer states, gray along idle -> lead -> convert
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_LEAD = 2'b01,
		ST_CONV = 2'b11
	} seq_state_t;

	// data-rate field encoding
	typedef enum logic [1:0]
	{
		RATE_20   = 2'b00,
		RATE_90   = 2'b01,
		RATE_330  = 2'b10,
		RATE_1000 = 2'b11
	} rate_sel_t;

endpackage

// ### rtl/osc_tick_gen.sv
// internal oscillator model: half-period, oscillator and modulator ticks
`timescale 1ns/100ps
`include "adc_seq_defs.svh"

module osc_tick_gen #(
	parameter int          ACC_W = 17,
	parameter logic [16:0] INC   = `HALF_OSC_KHZ,
	parameter logic [16:0] MODV  = `CORE_KHZ
) (
	input  wire logic core_clk,   // system clock
	input  wire logic rst_n,      // synchronous reset, active low
	input  wire logic osc_en,     // oscillator running
	output logic      half_tick,  // one pulse per oscillator half period
	output logic      osc_tick,   // one pulse per oscillator period
	output logic      mod_tick    // one pulse per four oscillator periods
);

	logic [ACC_W-1:0] acc_q;
	logic [2:0]       phase_q;
	logic [ACC_W-1:0] acc_sum;
	logic             wrap;

	// fractional accumulator gives the 2.048 MHz half-period rate
	assign acc_sum = acc_q + INC;
	assign wrap    = (acc_sum >= MODV);

	// -------------------------------------------------------------------------
	// accumulator, stopped and cleared while the oscillator is off
	// -------------------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (!rst_n || !osc_en)
			acc_q <= '0;
		else if (wrap)
			acc_q <= acc_sum - MODV;
		else
			acc_q <= acc_sum;
	end

	// half-period phase: odd phases end an oscillator period
	always_ff @(posedge core_clk)
	begin
		if (!rst_n || !osc_en)
			phase_q <= 3'h0;
		else if (wrap)
			phase_q <= phase_q + 3'h1;
	end

	assign half_tick = osc_en && wrap;
	assign osc_tick  = half_tick && phase_q[0];
	assign mod_tick  = half_tick && (phase_q == 3'h7);

endmodule // osc_tick_gen

// ### tb/host_board_model.sv
// host board model: ready pin pull-up and the analog word source
`timescale 1ns/100ps

module host_board_model (
	input  wire logic        core_clk,    // system clock
	input  wire logic        rst_n,       // supply reset, active low
	input  wire logic        conv_start,  // a conversion begins
	input  wire logic        ready_oe,    // device pulls the ready pin low
	output logic      [23:0] sample,      // filter word seen by the device
	output logic             ready_pin_n  // resolved ready pin level
);
	// open drain with pull-up: a released pin reads high, never a stale value
	assign ready_pin_n = ready_oe ? 1'b0 : 1'b1;

	// new word for every conversion, steady while it runs
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			sample <= 24'h5A_3C01;
		else if (conv_start)
			sample <= sample + 24'h01_0203;
	end
endmodule // host_board_model

// ### tb/tb_adc_conversion_mode_sequencer.sv
// self-checking bench for the conversion mode sequencer
`timescale 1ns/100ps
`include "adc_seq_defs.svh"

module tb_adc_conversion_mode_sequencer;
	logic        core_clk, rst_n, reset_pin_n, reg_wr, reg_rd;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rd;
	logic [23:0] conv_data;
	logic        ready_pin_n, ready_oe, ref_ext_sel, analog_on;
	logic        modulator_rate, conv_start, ref_settled, mod_seen, start_seen;
	int          bad_count, n_tests, n, mod_gap;

	adc_conversion_mode_sequencer #(.POR_CYCLES(20)) dut (
		.core_clk(core_clk), .rst_n(rst_n), .reset_pin_n(reset_pin_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_data(conv_data),
		.result_ready_n_i(ready_pin_n), .result_ready_n_o(),
		.result_ready_n_oe(ready_oe), .ref_ext_sel(ref_ext_sel),
		.analog_on(analog_on), .modulator_rate(modulator_rate),
		.conv_start(conv_start), .ref_settled(ref_settled));

	host_board_model board (.core_clk(core_clk), .rst_n(rst_n), .conv_start(conv_start),
		.ready_oe(ready_oe), .sample(conv_data), .ready_pin_n(ready_pin_n));

	// ------------------------------------------------------------
	// clock, bus tasks and compares
	// ------------------------------------------------------------
	always #5 core_clk = ~core_clk;

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr    <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd   <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			bad_count++;
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		chk_val({31'h0, got}, {31'h0, exp});
	endtask

	task automatic chk_rng(input int got, input int lo, input int hi);
		n_tests++;
		if (got < lo || got > hi)
		begin
			$display("wrong value at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
			bad_count++;
		end
	endtask

	// start pulse falls before a task can look after its strobe edge: keep a one-cycle copy
	always @(posedge core_clk)
		start_seen <= (conv_start === 1'b1);

	// 0: conversion start pulse, 1: ready pulled low, 2: reference settled
	task automatic wait_for(input int which, input int lim, output int cnt);
		cnt = 0;
		do
		begin
			@(posedge core_clk);
			#1 cnt++;
		end
		while (cnt < lim && (which == 0 ? start_seen : which == 1 ? ready_oe : ref_settled) !== 1'b1);
	endtask

	task automatic final_report();
		$display("checks %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// modulator strobe spacing: four oscillator periods while powered
	always @(posedge core_clk)
	begin
		mod_gap <= mod_gap + 1;
		if (analog_on !== 1'b1 || conv_start === 1'b1)
			mod_seen <= 1'b0;
		else if (modulator_rate === 1'b1)
		begin
			if (mod_seen)
				chk_rng(mod_gap, 389, 392);
			mod_seen <= 1'b1;
			mod_gap  <= 1;
		end
	end

	// watchdog: the sequence needs about 1.1 ms
	initial
	begin
		#1_400_000;
		bad_count++;
		final_report();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		core_clk = 1'b0;
		rst_n = 1'b0;
		reset_pin_n = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		mod_gap = 0;
		mod_seen = 1'b0;
		bad_count = 0;
		n_tests = 0;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (25) @(posedge core_clk);
		// defaults after the power-on hold, unmapped read, idle sleep
		rd_reg(`REG_CFG, rd);
		chk_val(rd, 32'h0000_0000);
		rd_reg(`REG_STATUS, rd);
		chk_val(rd, 32'h0000_008C);
		chk_bit(ref_ext_sel, 1'b0);
		chk_bit(ready_pin_n, 1'b1);
		rd_reg(8'h20, rd);
		chk_val(rd, 32'h0000_0000);
		wr_reg(`REG_CMD, {24'h00_0000, `CMD_SLEEP});
		repeat (3) @(posedge core_clk);
		chk_bit(analog_on, 1'b0);
		// reference select and settle after going back to internal
		wr_reg(`REG_CFG, 32'h0000_0001);
		repeat (2) @(posedge core_clk);
		chk_bit(ref_ext_sel, 1'b1);
		wr_reg(`REG_CFG, 32'h0000_0000);
		wait_for(2, 4000, n);
		chk_rng(n, 2498, 2504);
		chk_bit(ref_ext_sel, 1'b0);
		// single shot at the fastest rate, restarted by a config write
		wr_reg(`REG_CFG, 32'h0000_000C);
		wr_reg(`REG_CMD, {24'h00_0000, `CMD_START});
		wait_for(0, 10, n);
		chk_rng(n, 1, 3);
		chk_bit(analog_on, 1'b1);
		repeat (500) @(posedge core_clk);
		wr_reg(`REG_CFG, 32'h0000_000C);
		wait_for(0, 10, n);
		chk_rng(n, 1, 3);
		wait_for(1, 110000, n);
		chk_rng(n, 103560, 103670);
		chk_bit(ready_pin_n, 1'b0);
		repeat (2) @(posedge core_clk);
		chk_bit(analog_on, 1'b0);
		wr_reg(`REG_CMD, {24'h00_0000, `CMD_READ_RESULT});
		repeat (3) @(posedge core_clk);
		chk_bit(ready_pin_n, 1'b1);
		// two start pulses advanced the board word twice; a second read returns the same word
		rd_reg(`REG_RESULT, rd);
		chk_val(rd, 32'h005C_4007);
		rd_reg(`REG_RESULT, rd);
		chk_val(rd, 32'h005C_4007);
		// continuous: lead time, restart by config write, sleep pending
		wr_reg(`REG_CFG, 32'h0000_000E);
		wr_reg(`REG_CMD, {24'h00_0000, `CMD_START});
		wait_for(0, 4000, n);
		chk_rng(n, 2760, 2810);
		repeat (300) @(posedge core_clk);
		wr_reg(`REG_CFG, 32'h0000_000E);
		wait_for(0, 10, n);
		chk_rng(n, 1, 4);
		wr_reg(`REG_CMD, {24'h00_0000, `CMD_SLEEP});
		repeat (20) @(posedge core_clk);
		rd_reg(`REG_STATUS, rd);
		chk_val(rd, 32'h0000_00DF);
		rd_reg(`REG_CFG, rd);
		chk_val(rd, 32'h0000_000E);
		// reset commands 06h and 07h, general call 06h and the reset pin each abort a running sequence
		for (int k = 0; k < 4; k++)
		begin
			wr_reg(`REG_CFG, 32'h0000_000F);
			wr_reg(`REG_CMD, {24'h00_0000, `CMD_START});
			repeat (20) @(posedge core_clk);
			if (k == 3)
			begin
				reset_pin_n <= 1'b0;
				repeat (3) @(posedge core_clk);
				reset_pin_n <= 1'b1;
			end
			else
				wr_reg(k == 2 ? `REG_GCALL : `REG_CMD, k == 1 ? 32'h0000_0007 : 32'h0000_0006);
			repeat (30) @(posedge core_clk);
			chk_bit(analog_on, 1'b0);
			chk_bit(ref_ext_sel, 1'b0);
			rd_reg(`REG_CFG, rd);
			chk_val(rd, 32'h0000_0000);
		end
		final_report();
	end
endmodule // tb_adc_conversion_mode_sequencer
